// [hdl/asg_gate.sv]
`timescale 1ns/1ps
`include "asg_regs.svh"
// ***************************************************************
// Notes on behaviour
// RL1: the burst frame count holds only 1 to 255 while gating is enabled.
// RL2: with gating on, starting acquisition enters waiting-for-start.
// RL3: while waiting for start, frame triggers are ignored and no exposure starts.
// RL4: a valid start trigger while waiting moves to waiting-for-frame, where frame triggers are taken.
// RL5: accepted frame triggers are counted and the gate rearms when the count equals the burst count.
// RL6: after a burst the controller must give a new start trigger before more frames.
// RL7: every new start trigger after a burst reopens the gate, repeating without end.
// RL8: with gating on and software origin, the host issues a software start first.
// RL9: the host points the target selector at the start trigger, then issues the software command.
// RL10: while the selector addresses the start trigger, each software command is one start event.
// RL11: the host keeps the run style continuous while gating is on.
// RL12: with gating off, start triggers are made internally and none is needed from outside.
// RL13: with line one as origin, the chosen edge polarity gives the start trigger.
// RL14: a stop or reset clears the frame counter and returns to waiting-for-start; here both return to idle instead.
// ***************************************************************
module asg_gate (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// acquisition commands, one-cycle pulses
	input wire logic acq_start,
	input wire logic acq_stop,
	// configuration
	input wire asg_pkg::asg_cfg_t cfg,
	input wire logic target_sel,
	// triggers
	input wire logic soft_trig,
	input wire logic line_in,
	input wire logic frame_trig,
	// results
	output logic expose_start,
	output logic waiting_start,
	output logic waiting_frame,
	output logic [7:0] frame_cnt,
	output logic count_err
);
	typedef struct packed {
		asg_pkg::asg_state_t state;
		logic [7:0] burst;
		logic [7:0] cnt;
		logic expose;
		logic err;
		logic wait_s;
		logic wait_f;
	} asg_gate_st_t;
	asg_gate_st_t st_r;
	asg_gate_st_t st_nxt;
	logic line_edge;
	logic start_evt;

	// ***************************************************************
	// start trigger sources
	// ***************************************************************
	asg_line_edge u_edge (
		.mclk(mclk),
		.reset_n(reset_n),
		.line_in(line_in),
		.edge_sel(cfg.edge_sel),
		.edge_pulse(line_edge)
	);

	// software command counts only when aimed at the start trigger
	always_comb begin
		if (cfg.src == `ASG_SRC_LINE1) begin
			start_evt = line_edge; // see RL13
		end else begin
			start_evt = soft_trig && (target_sel == `ASG_SEL_START); // see RL10
		end
	end

	// ***************************************************************
	// gating state machine
	// ***************************************************************
	always_comb begin
		st_nxt = st_r;
		st_nxt.expose = 1'b0;
		// a zero count is out of range; keep the old value and flag it while gating is enabled
		if (cfg.burst_count < `ASG_COUNT_MIN) begin // see RL1
			st_nxt.err = cfg.gate_en;
		end else begin
			st_nxt.err = 1'b0;
			if (st_r.state != asg_pkg::ASG_WAIT_FRAME) begin
				st_nxt.burst = cfg.burst_count; // only latched between bursts
			end
		end
		case (st_r.state)
			asg_pkg::ASG_IDLE: begin
				if (acq_start) begin
					st_nxt.cnt = 8'h00;
					st_nxt.state = cfg.gate_en ? asg_pkg::ASG_WAIT_START : asg_pkg::ASG_WAIT_FRAME; // see RL2
				end
			end
			asg_pkg::ASG_WAIT_START: begin
				// frame triggers dropped here, so no exposure starts; see RL3
				if (!cfg.gate_en) begin // see RL12
					st_nxt.state = asg_pkg::ASG_WAIT_FRAME;
				end else if (start_evt) begin // see RL4
					st_nxt.state = asg_pkg::ASG_WAIT_FRAME; // see RL7
					st_nxt.cnt = 8'h00;
				end
			end
			asg_pkg::ASG_WAIT_FRAME: begin
				if (frame_trig) begin // see RL4
					st_nxt.expose = 1'b1;
					if (cfg.gate_en) begin
						if (st_r.cnt + 8'h01 == st_r.burst) begin // see RL5
							st_nxt.cnt = 8'h00;
							st_nxt.state = asg_pkg::ASG_WAIT_START;
						end else begin
							st_nxt.cnt = st_r.cnt + 8'h01;
						end
					end
				end
			end
			default: begin
				st_nxt.state = asg_pkg::ASG_IDLE;
			end
		endcase
		if (acq_stop) begin // see RL14
			st_nxt.state = asg_pkg::ASG_IDLE;
			st_nxt.cnt = 8'h00;
			st_nxt.expose = 1'b0;
		end
		// status flags are registered copies of the next state, so the pins never glitch
		st_nxt.wait_s = (st_nxt.state == asg_pkg::ASG_WAIT_START); // see RL2
		st_nxt.wait_f = (st_nxt.state == asg_pkg::ASG_WAIT_FRAME); // see RL4
	end

	// synchronous reset; the burst latch restarts at the smallest legal count
	always_ff @(posedge mclk) begin
		if (!reset_n) begin // see RL14
			st_r.state <= asg_pkg::ASG_IDLE;
			st_r.burst <= `ASG_COUNT_RST;
			st_r.cnt <= 8'h00;
			st_r.expose <= 1'b0;
			st_r.err <= 1'b0;
			st_r.wait_s <= 1'b0;
			st_r.wait_f <= 1'b0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expose_start = st_r.expose;
	// every output is a plain flip-flop of the state record
	assign waiting_start = st_r.wait_s;
	assign waiting_frame = st_r.wait_f;
	assign frame_cnt = st_r.cnt;
	assign count_err = st_r.err;

	// ***************************************************************
	// checks
	// ***************************************************************
	// burst count range: a zero request is refused and the latch keeps its old value
	chk_burst_range: assert property (@(posedge mclk) disable iff (!reset_n) st_r.burst >= `ASG_COUNT_MIN) // see RL1
		else $error("burst count out of range");
	chk_count_flag: assert property (@(posedge mclk) disable iff (!reset_n) // see RL1
		cfg.gate_en && cfg.burst_count == 8'h00 |=> st_r.err)
		else $error("zero burst count not flagged");
	chk_burst_hold: assert property (@(posedge mclk) disable iff (!reset_n) // see RL1
		cfg.burst_count == 8'h00 |=> st_r.burst == $past(st_r.burst))
		else $error("zero burst count was latched");
	// entering and leaving the wait for start
	chk_start_enter: assert property (@(posedge mclk) disable iff (!reset_n) // see RL2
		st_r.state == asg_pkg::ASG_IDLE && acq_start && cfg.gate_en && !acq_stop
		|=> st_r.state == asg_pkg::ASG_WAIT_START)
		else $error("start did not enter wait for start");
	chk_flag_match: assert property (@(posedge mclk) disable iff (!reset_n) // see RL2
		waiting_start == (st_r.state == asg_pkg::ASG_WAIT_START)
		&& waiting_frame == (st_r.state == asg_pkg::ASG_WAIT_FRAME))
		else $error("status flags disagree with state");
	chk_no_expose: assert property (@(posedge mclk) disable iff (!reset_n) // see RL3
		st_r.state != asg_pkg::ASG_WAIT_FRAME |=> !st_r.expose)
		else $error("exposure outside frame wait");
	chk_frame_ignored: assert property (@(posedge mclk) disable iff (!reset_n) // see RL3
		st_r.state == asg_pkg::ASG_WAIT_START && frame_trig && cfg.gate_en && !start_evt && !acq_stop
		|=> st_r.state == asg_pkg::ASG_WAIT_START && !st_r.expose && st_r.cnt == 8'h00)
		else $error("frame trigger taken while waiting for start");
	chk_start_exit: assert property (@(posedge mclk) disable iff (!reset_n) // see RL4
		st_r.state == asg_pkg::ASG_WAIT_START && cfg.gate_en && start_evt && !acq_stop
		|=> st_r.state == asg_pkg::ASG_WAIT_FRAME && st_r.cnt == 8'h00)
		else $error("start trigger not taken");
	// counting inside a burst and rearming at its end
	chk_frame_count: assert property (@(posedge mclk) disable iff (!reset_n) // see RL5
		st_r.state == asg_pkg::ASG_WAIT_FRAME && cfg.gate_en && frame_trig && !acq_stop
		&& st_r.cnt + 8'h01 != st_r.burst
		|=> st_r.expose && st_r.state == asg_pkg::ASG_WAIT_FRAME && st_r.cnt == $past(st_r.cnt) + 8'h01)
		else $error("accepted frame not counted");
	chk_burst_end: assert property (@(posedge mclk) disable iff (!reset_n) // see RL5
		st_r.state == asg_pkg::ASG_WAIT_FRAME && cfg.gate_en && frame_trig && !acq_stop
		&& st_r.cnt + 8'h01 == st_r.burst
		|=> st_r.expose && st_r.state == asg_pkg::ASG_WAIT_START)
		else $error("burst did not rearm");
	// start sources: only the selected origin may open the gate
	chk_soft_select: assert property (@(posedge mclk) disable iff (!reset_n) // see RL10
		cfg.src == `ASG_SRC_SOFT && soft_trig && target_sel == `ASG_SEL_FRAME |-> !start_evt)
		else $error("software command taken while aimed elsewhere");
	chk_soft_aimed: assert property (@(posedge mclk) disable iff (!reset_n) // see RL10
		cfg.src == `ASG_SRC_SOFT && soft_trig && target_sel == `ASG_SEL_START |-> start_evt)
		else $error("aimed software command not taken");
	chk_line_only: assert property (@(posedge mclk) disable iff (!reset_n) // see RL13
		cfg.src == `ASG_SRC_LINE1 && soft_trig && !line_edge |-> !start_evt)
		else $error("software command taken with line origin");
	// gating off: no start trigger needed from outside
	chk_gate_off: assert property (@(posedge mclk) disable iff (!reset_n) // see RL12
		!cfg.gate_en && st_r.state == asg_pkg::ASG_WAIT_START && !acq_stop
		|=> st_r.state == asg_pkg::ASG_WAIT_FRAME)
		else $error("gating off still waits for start");
	chk_open_direct: assert property (@(posedge mclk) disable iff (!reset_n) // see RL12
		st_r.state == asg_pkg::ASG_IDLE && acq_start && !cfg.gate_en && !acq_stop
		|=> st_r.state == asg_pkg::ASG_WAIT_FRAME && st_r.cnt == 8'h00)
		else $error("gate off start did not open the gate");
	// stop and reset both clear the burst
	chk_stop_clear: assert property (@(posedge mclk) disable iff (!reset_n) // see RL14
		acq_stop |=> st_r.state == asg_pkg::ASG_IDLE && st_r.cnt == 8'h00 && !st_r.expose)
		else $error("stop did not clear");
	chk_reset_idle: assert property (@(posedge mclk) // see RL14
		!reset_n |=> st_r.state == asg_pkg::ASG_IDLE && st_r.cnt == 8'h00 && !waiting_start && !waiting_frame)
		else $error("reset did not return to idle");
endmodule : asg_gate

// [hdl/asg_regs.svh]
`ifndef ASG_REGS_SVH
`define ASG_REGS_SVH
// burst frame count limits and reset value
`define ASG_COUNT_MIN 8'h01
`define ASG_COUNT_MAX 8'hFF
`define ASG_COUNT_RST 8'h01
// trigger origin encoding
`define ASG_SRC_SOFT 1'b0
`define ASG_SRC_LINE1 1'b1
// edge polarity encoding
`define ASG_EDGE_RISE 1'b0
`define ASG_EDGE_FALL 1'b1
// trigger target selector encoding
`define ASG_SEL_FRAME 1'b0
`define ASG_SEL_START 1'b1
`endif

// [hdl/asg_pkg.sv]
package asg_pkg;
	// gating state
	typedef enum logic [1:0] {
		ASG_IDLE,
		ASG_WAIT_START,
		ASG_WAIT_FRAME
	} asg_state_t;
	// static configuration of the gate
	typedef struct packed {
		logic gate_en;
		logic src;
		logic edge_sel;
		logic [7:0] burst_count;
	} asg_cfg_t;
endpackage : asg_pkg

// [hdl/asg_line_edge.sv]
`timescale 1ns/1ps
`include "asg_regs.svh"
// synchronises the external line and reports the selected edge
module asg_line_edge (
	// clock and reset
	input wire logic mclk,
	input wire logic reset_n,
	// line and selection
	input wire logic line_in,
	input wire logic edge_sel,
	// result
	output logic edge_pulse
);
	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic pulse;
		logic [1:0] live;
	} asg_edge_st_t;
	asg_edge_st_t st_r;
	asg_edge_st_t st_nxt;

	// two-stage sync, then compare stages two and three only
	// no edge is reported until stage three holds a real sample: a line idling high
	// would otherwise look like a rising edge straight after reset
	always_comb begin
		st_nxt = st_r;
		st_nxt.s1 = line_in;
		st_nxt.s2 = st_r.s1;
		st_nxt.s3 = st_r.s2;
		st_nxt.live = (st_r.live == 2'h3) ? 2'h3 : st_r.live + 2'h1;
		if (st_r.live != 2'h3) begin
			st_nxt.pulse = 1'b0;
		end else if (edge_sel == `ASG_EDGE_FALL) begin // see RL13
			st_nxt.pulse = st_r.s3 & ~st_r.s2;
		end else begin
			st_nxt.pulse = ~st_r.s3 & st_r.s2;
		end
	end

	always_ff @(posedge mclk) begin
		if (!reset_n) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign edge_pulse = st_r.pulse;

	chk_edge_quiet: assert property (@(posedge mclk) disable iff (!reset_n) // see RL13
		st_r.live != 2'h3 |=> !st_r.pulse)
		else $error("line edge reported before sync filled");
endmodule : asg_line_edge

// [verification/asg_host_model.sv]
`timescale 1ns/1ps
// ****************
// host and line one
// ****************
module asg_host_model (
	// clock
	input wire logic mclk,
	// requests from the bench
	input wire logic soft_req,
	input wire logic aim_start,
	input wire logic line_req,
	// toward the gate
	output logic target_sel,
	output logic soft_trig,
	output logic line_in
);
	logic pend;
	initial begin
		target_sel = 1'b0;
		soft_trig = 1'b0;
		line_in = 1'b0;
		pend = 1'b0;
	end
	// acts a step after the bench so both never move in one time step
	always @(posedge mclk) begin
		#2;
		soft_trig = pend;
		pend = soft_req;
		if (soft_req) target_sel = aim_start;
		if (line_req) line_in = ~line_in;
	end
endmodule : asg_host_model

// [verification/tb.sv]
`timescale 1ns/1ps
module tb;
	logic mclk = 1'b0, reset_n = 1'b0, acq_start = 1'b0, acq_stop = 1'b0, frame_trig = 1'b0;
	logic soft_req = 1'b0, aim = 1'b0, line_req = 1'b0, target_sel, soft_trig, line_in;
	logic expose_start, waiting_start, waiting_frame, count_err;
	logic [7:0] frame_cnt;
	asg_pkg::asg_cfg_t cfg = '0;
	int err_total = 0, num_checks = 0, st, cnt, bl, s1, s2, s3, p, ex, ce, pn, ev, lv;
	bit [31:0] seed = 32'hC5333D75;
	always #5 mclk = ~mclk;
	asg_gate i_dut (.mclk(mclk), .reset_n(reset_n), .acq_start(acq_start), .acq_stop(acq_stop), .cfg(cfg),
		.target_sel(target_sel), .soft_trig(soft_trig), .line_in(line_in), .frame_trig(frame_trig),
		.expose_start(expose_start), .waiting_start(waiting_start), .waiting_frame(waiting_frame),
		.frame_cnt(frame_cnt), .count_err(count_err));
	asg_host_model i_host (.mclk(mclk), .soft_req(soft_req), .aim_start(aim), .line_req(line_req),
		.target_sel(target_sel), .soft_trig(soft_trig), .line_in(line_in));
	function bit [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd
	// ****************
	// reference model
	// ****************
	// line path mirrors two sync stages plus a detect register; no edge before stage three is filled
	always @(posedge mclk) begin
		if (!reset_n) begin
			{st, cnt, s1, s2, s3, p, ex, ce, lv} = '0;
			bl = 1;
		end else begin
			pn = (lv == 3) && (s2 != s3) && (s2 == (cfg.edge_sel ? 0 : 1));
			ev = cfg.src ? p : (soft_trig && target_sel);
			ex = 0;
			if (st != 2 && cfg.burst_count != 8'h00) bl = cfg.burst_count;
			if (acq_stop) begin
				st = 0;
				cnt = 0;
			end else if (st == 0 && acq_start) st = cfg.gate_en ? 1 : 2;
			else if (st == 1 && (!cfg.gate_en || ev)) st = 2;
			else if (st == 2 && frame_trig) begin
				ex = 1;
				if (cfg.gate_en) cnt++;
				if (cfg.gate_en && cnt == bl) begin
					st = 1;
					cnt = 0;
				end
			end
			ce = cfg.gate_en && cfg.burst_count == 8'h00;
			p = pn;
			s3 = s2;
			s2 = s1;
			s1 = line_in;
			lv = (lv < 3) ? lv + 1 : 3;
		end
	end
	// compare at the falling edge once every update has landed
	always @(negedge mclk) begin
		if (reset_n) begin
			num_checks++;
			if ({expose_start, waiting_start, waiting_frame, frame_cnt, count_err} !== {ex[0], st == 1, st == 2, cnt[7:0], ce[0]}) begin
				err_total++;
				$display("Error %0t: gate outputs differ from model", $time);
			end
		end
	end
	task cyc(input int n);
		repeat (n) @(posedge mclk);
		#1;
	endtask : cyc
	// random triggers, stray starts and line toggles
	task run(input int n);
		repeat (n) begin
			frame_trig = rnd() % 2;
			soft_req = (rnd() % 8 == 0);
			line_req = (rnd() % 12 == 0);
			acq_start = (rnd() % 64 == 0);
			cyc(1);
		end
		{frame_trig, soft_req, line_req, acq_start} = '0;
	endtask : run
	task give_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : give_verdict
	// ****************
	// tests
	// ****************
	// cases: soft, misaimed soft, line rise, line fall, gate off (while waiting and from idle), 255 frames, zero count
	initial begin
		cyc(10);
		reset_n = 1'b1;
		for (int i = 0; i < 7; i++) begin
			if (i == 3) begin
				reset_n = 1'b0;
				cyc(3);
				reset_n = 1'b1;
			end
			cfg.gate_en = 1'b1;
			cfg.src = (i == 2 || i == 3);
			cfg.edge_sel = (i == 3);
			cfg.burst_count = (i == 5) ? 8'hFF : (i == 6) ? 8'h00 : 8'(rnd() % 8 + 1);
			aim = (i != 1);
			acq_start = 1'b1;
			cyc(1);
			acq_start = 1'b0;
			// test 4 turns gating off while the gate waits for start
			cfg.gate_en = (i != 4);
			cyc(1);
			run(i == 5 ? 1500 : 300);
			acq_stop = 1'b1;
			cyc(1);
			acq_stop = 1'b0;
			cyc(2);
			// gating still off: a start from idle must open the gate at once
			if (i == 4) begin
				acq_start = 1'b1;
				cyc(1);
				acq_start = 1'b0;
				frame_trig = 1'b1;
				cyc(2);
				frame_trig = 1'b0;
				acq_stop = 1'b1;
				cyc(1);
				acq_stop = 1'b0;
				cyc(2);
			end
			$display("test %0d done", i);
		end
		give_verdict();
	end
	// hang guard, well beyond the few thousand cycles of the tests
	initial begin
		#200000;
		err_total++;
		give_verdict();
	end
endmodule : tb
